// >>> core/fp_status_skip_trap_unit.sv
// status word, skip and trap logic of the floating-point unit
// assumes the sequencer presents one operation per valid cycle
`timescale 1ns/1ns
`default_nettype none
module fp_status_skip_trap_unit #(
	parameter logic [3:0] FPU_KIND = fp_status_pkg::FPU_KIND_DEFAULT
) (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// operation from the sequencer
	input  wire logic                         op_valid_i,
	input  wire fp_status_pkg::op_req_s       op_i,
	input  wire fp_status_pkg::dp_result_s    dp_i,
	input  wire logic [31:0]                  load_data_i,
	// flow control to the sequencer
	output logic [14:0]                       pc_o,
	output logic                              skip_o,
	output logic                              trap_o,
	// result and status
	output logic                              result_write_o,
	output logic [6:0]                        exp_field_o,
	output logic [63:0]                       status_o,
	output logic [31:0]                       store_data_o,
	output logic                              store_valid_o
);
	typedef struct packed {
		fp_status_pkg::fp_status_s st;
		logic                      fault_pend;
		logic [14:0]               pc;
		logic                      skip;
		logic                      trap;
		logic                      wr;
		logic [6:0]                exp;
		logic [31:0]               store;
		logic                      store_v;
	} state_s;

	state_s s_q;
	state_s s_d;

	fp_status_pkg::fp_status_s st_view;
	logic                      is_skip;
	logic                      take;
	logic [6:0]                exp_field;
	logic                      exp_high;
	logic                      exp_low;
	logic                      fault_now;
	logic                      is_fp;

	// summary bit derived from fault flags
	function automatic fp_status_pkg::fp_status_s view(input fp_status_pkg::fp_status_s s,
		input logic [3:0] kind);
		fp_status_pkg::fp_status_s v;
		v         = s;
		v.any_err = s.exp_high | s.exp_low | s.divisor_nil | s.frac_carry;
		v.kind    = kind;
		v.rsv_mid = 4'h0;
		v.rsv_hi  = 1'b0;
		return v;
	endfunction

	assign st_view = view(s_q.st, FPU_KIND);

	fp_skip_decide u_skip (
		.op_i      (op_i.op),
		.st_i      (st_view),
		.is_skip_o (is_skip),
		.take_o    (take)
	);

	fp_exp_wrap u_exp (
		.raw_i   (dp_i.raw_exp),
		.field_o (exp_field),
		.high_o  (exp_high),
		.low_o   (exp_low)
	);

	assign is_fp = op_i.op != fp_status_pkg::OP_FIXED;

	always_comb begin
		s_d         = s_q;
		s_d.skip    = 1'b0;
		s_d.trap    = 1'b0;
		s_d.wr      = 1'b0;
		s_d.store_v = 1'b0;
		fault_now   = 1'b0;
		if (op_valid_i) begin
			if (is_fp && s_q.fault_pend && s_q.st.trap_allow) begin
				s_d.trap       = 1'b1;
				s_d.fault_pend = 1'b0;
				s_d.pc         = op_i.pc;
			end else begin
				if (is_fp)
					s_d.fault_pend = 1'b0;
				s_d.pc = op_i.pc + (op_i.two_word ? fp_status_pkg::PC_STEP_TWO
					: fp_status_pkg::PC_STEP_ONE);
				if (is_skip && take) begin
					s_d.skip = 1'b1;
					s_d.pc   = op_i.pc + fp_status_pkg::PC_STEP_TWO;
				end
				case (op_i.op)
					fp_status_pkg::OP_ARITH: begin
						s_d.wr  = 1'b1;
						s_d.exp = exp_field;
						s_d.st.exp_high   = s_q.st.exp_high | exp_high;
						s_d.st.exp_low    = s_q.st.exp_low | exp_low;
						s_d.st.frac_carry = s_q.st.frac_carry | dp_i.frac_carry;
						s_d.st.result_nil = dp_i.nil;
						s_d.st.below_zero = dp_i.neg;
						fault_now = exp_high | exp_low | dp_i.frac_carry;
					end
					fp_status_pkg::OP_DIVIDE: begin
						if (dp_i.divisor_nil) begin
							s_d.st.divisor_nil = 1'b1;
							fault_now = 1'b1;
						end else begin
							s_d.wr  = 1'b1;
							s_d.exp = exp_field;
							s_d.st.exp_high   = s_q.st.exp_high | exp_high;
							s_d.st.exp_low    = s_q.st.exp_low | exp_low;
							s_d.st.frac_carry = s_q.st.frac_carry | dp_i.frac_carry;
							s_d.st.result_nil = dp_i.nil;
							s_d.st.below_zero = dp_i.neg;
							fault_now = exp_high | exp_low | dp_i.frac_carry;
						end
					end
					fp_status_pkg::OP_COMPARE: begin
						s_d.st.result_nil = dp_i.nil;
						s_d.st.below_zero = dp_i.neg;
					end
					fp_status_pkg::OP_CLEAR_ERRORS: begin
						s_d.st.exp_high    = 1'b0;
						s_d.st.exp_low     = 1'b0;
						s_d.st.divisor_nil = 1'b0;
						s_d.st.frac_carry  = 1'b0;
						s_d.st.any_err     = 1'b0;
					end
					fp_status_pkg::OP_LOAD_STATUS: begin
						s_d.st = load_data_i;
					end
					fp_status_pkg::OP_STORE_STATUS: begin
						s_d.store   = st_view;
						s_d.store_v = 1'b1;
					end
					fp_status_pkg::OP_TRAP_ON:  s_d.st.trap_allow = 1'b1;
					fp_status_pkg::OP_TRAP_OFF: s_d.st.trap_allow = 1'b0;
					default: ;
				endcase
				if (fault_now) begin
					s_d.st.fault_pc = op_i.pc;
					s_d.fault_pend  = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign status_o       = {32'h0000_0000, view(s_q.st, FPU_KIND)};
	assign pc_o           = s_q.pc;
	assign skip_o         = s_q.skip;
	assign trap_o         = s_q.trap;
	assign result_write_o = s_q.wr;
	assign exp_field_o    = s_q.exp;
	assign store_data_o   = s_q.store;
	assign store_valid_o  = s_q.store_v;

	// checks
	property p_any_summary;
		@(posedge clk_i) disable iff (rst_i)
		status_o[fp_status_pkg::ANY_BIT] == (|status_o[4:1]);
	endproperty
	a_any_summary: assert property (p_any_summary) else $error("summary bit wrong");

	property p_skip_pc;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && !trap_o ##1 skip_o |-> pc_o == $past(op_i.pc) + fp_status_pkg::PC_STEP_TWO;
	endproperty
	a_skip_pc: assert property (p_skip_pc) else $error("skip pc not plus two");

	property p_always_skip;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && op_i.op == fp_status_pkg::OP_SKIP_ALWAYS
			&& !(s_q.fault_pend && s_q.st.trap_allow) |=> skip_o;
	endproperty
	a_always_skip: assert property (p_always_skip) else $error("skip always missed");

	property p_never_skip;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && (op_i.op == fp_status_pkg::OP_NEVER_SKIP
			|| op_i.op == fp_status_pkg::OP_COMPARE) |=> !skip_o;
	endproperty
	a_never_skip: assert property (p_never_skip) else $error("unexpected skip");

	property p_gt_skip;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && op_i.op == fp_status_pkg::OP_SKIP_IF_GT && !s_q.fault_pend
			|=> skip_o == !($past(status_o[6]) || $past(status_o[7]));
	endproperty
	a_gt_skip: assert property (p_gt_skip) else $error("greater skip wrong");

	property p_clear;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && op_i.op == fp_status_pkg::OP_CLEAR_ERRORS && !trap_o
			&& !(s_q.fault_pend && s_q.st.trap_allow)
			|=> status_o[4:0] == 5'h00 && status_o[31:5] == $past(status_o[31:5]);
	endproperty
	a_clear: assert property (p_clear) else $error("clear errors wrong");

	property p_divzero_abort;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && op_i.op == fp_status_pkg::OP_DIVIDE && dp_i.divisor_nil
			&& !(s_q.fault_pend && s_q.st.trap_allow)
			|=> !result_write_o && status_o[fp_status_pkg::DIV_NIL_BIT]
			&& status_o[31:17] == $past(op_i.pc);
	endproperty
	a_divzero_abort: assert property (p_divzero_abort) else $error("divide fault wrong");

	property p_sticky;
		@(posedge clk_i) disable iff (rst_i)
		status_o[fp_status_pkg::EXP_HIGH_BIT] && !(op_valid_i
			&& (op_i.op == fp_status_pkg::OP_CLEAR_ERRORS
			|| op_i.op == fp_status_pkg::OP_LOAD_STATUS))
			|=> status_o[fp_status_pkg::EXP_HIGH_BIT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault flag lost");

	property p_trap;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && op_i.op != fp_status_pkg::OP_FIXED && s_q.fault_pend
			&& status_o[fp_status_pkg::TRAP_ALLOW_BIT]
			|=> trap_o && !skip_o && pc_o == $past(op_i.pc);
	endproperty
	a_trap: assert property (p_trap) else $error("trap not taken");

	property p_kind;
		@(posedge clk_i) disable iff (rst_i)
		status_o[15:12] == FPU_KIND && status_o[11:8] == 4'h0 && !status_o[16];
	endproperty
	a_kind: assert property (p_kind) else $error("kind or reserved bits wrong");

	property p_seq_step;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && op_i.op == fp_status_pkg::OP_FIXED && op_i.two_word
			|=> pc_o == $past(op_i.pc) + fp_status_pkg::PC_STEP_TWO;
	endproperty
	a_seq_step: assert property (p_seq_step) else $error("two-word step wrong");

	property p_div_write;
		@(posedge clk_i) disable iff (rst_i)
		op_valid_i && op_i.op == fp_status_pkg::OP_DIVIDE && !dp_i.divisor_nil
			&& !(s_q.fault_pend && s_q.st.trap_allow)
			|=> result_write_o && exp_field_o == $past(dp_i.raw_exp[6:0]);
	endproperty
	a_div_write: assert property (p_div_write) else $error("divide result not written");

	c_skip_taken: cover property (@(posedge clk_i) disable iff (rst_i) skip_o);
	c_trap_taken: cover property (@(posedge clk_i) disable iff (rst_i) trap_o);
	c_store_out:  cover property (@(posedge clk_i) disable iff (rst_i) store_valid_o);
	c_overflow:   cover property (@(posedge clk_i) disable iff (rst_i)
		op_valid_i && op_i.op == fp_status_pkg::OP_ARITH && exp_high);
endmodule
`default_nettype wire

// >>> common/fp_status_pkg.sv
// package for the floating-point status and skip unit
// assumes a single processor clock shared by all users
package fp_status_pkg;

	// bit positions of the status word
	localparam int unsigned ANY_BIT        = 0;
	localparam int unsigned EXP_HIGH_BIT   = 1;
	localparam int unsigned EXP_LOW_BIT    = 2;
	localparam int unsigned DIV_NIL_BIT    = 3;
	localparam int unsigned FRAC_CARRY_BIT = 4;
	localparam int unsigned TRAP_ALLOW_BIT = 5;
	localparam int unsigned RESULT_NIL_BIT = 6;
	localparam int unsigned BELOW_ZERO_BIT = 7;
	localparam int unsigned KIND_LSB       = 12;
	localparam int unsigned FAULT_PC_LSB   = 17;

	// widths
	localparam int unsigned PC_W       = 15;
	localparam int unsigned STATUS_W   = 64;
	localparam int unsigned LOAD_W     = 32;
	localparam int unsigned EXP_W      = 7;
	localparam int unsigned RAW_EXP_W  = 9;

	// program counter steps
	localparam logic [14:0] PC_STEP_ONE  = 15'h0001;
	localparam logic [14:0] PC_STEP_TWO  = 15'h0002;
	localparam logic [14:0] PC_RESET     = 15'h0000;

	// exponent limits, excess-64 seven-bit field
	localparam logic signed [8:0] EXP_MAX = 9'sh07F;
	localparam logic signed [8:0] EXP_MIN = 9'sh000;

	// reset value of the software-visible status bits
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

	// identification of the unit; value is arbitrary
	localparam logic [3:0] FPU_KIND_DEFAULT = 4'h5;

	typedef enum logic [4:0] {
		OP_FIXED,
		OP_ARITH,
		OP_DIVIDE,
		OP_COMPARE,
		OP_NEVER_SKIP,
		OP_SKIP_ALWAYS,
		OP_SKIP_IF_NIL,
		OP_SKIP_IF_NOT_NIL,
		OP_SKIP_IF_GE,
		OP_SKIP_IF_LT,
		OP_SKIP_IF_GT,
		OP_SKIP_IF_LE,
		OP_SKIP_IF_NO_DIVZERO,
		OP_SKIP_IF_NO_ERROR,
		OP_SKIP_IF_NO_FRACCARRY,
		OP_SKIP_IF_NO_OVF,
		OP_SKIP_IF_NO_UNF,
		OP_SKIP_NO_HIGH_NO_DIVZERO,
		OP_SKIP_NO_LOW_NO_DIVZERO,
		OP_SKIP_NO_LOW_NO_HIGH,
		OP_CLEAR_ERRORS,
		OP_LOAD_STATUS,
		OP_STORE_STATUS,
		OP_TRAP_ON,
		OP_TRAP_OFF
	} op_e;

	// status word, low 32 bits, bit 0 at the right
	typedef struct packed {
		logic [14:0] fault_pc;
		logic        rsv_hi;
		logic [3:0]  kind;
		logic [3:0]  rsv_mid;
		logic        below_zero;
		logic        result_nil;
		logic        trap_allow;
		logic        frac_carry;
		logic        divisor_nil;
		logic        exp_low;
		logic        exp_high;
		logic        any_err;
	} fp_status_s;

	// one instruction from the sequencer
	typedef struct packed {
		op_e         op;
		logic [14:0] pc;
		logic        two_word;
	} op_req_s;

	// outcome of the floating-point datapath for this instruction
	typedef struct packed {
		logic [8:0]  raw_exp;
		logic        frac_carry;
		logic        nil;
		logic        neg;
		logic        divisor_nil;
	} dp_result_s;

endpackage

// >>> core/fp_skip_decide.sv
// skip condition decoder for the floating-point skip operations
// assumes status flags are stable while the operation is presented
`timescale 1ns/1ns
`default_nettype none
module fp_skip_decide (
	// operation and flags
	input  wire fp_status_pkg::op_e   op_i,
	input  wire fp_status_pkg::fp_status_s st_i,
	// decision
	output logic                      is_skip_o,
	output logic                      take_o
);
	always_comb begin
		is_skip_o = 1'b1;
		take_o    = 1'b0;
		case (op_i)
			fp_status_pkg::OP_NEVER_SKIP:              take_o = 1'b0;
			fp_status_pkg::OP_SKIP_ALWAYS:             take_o = 1'b1;
			fp_status_pkg::OP_SKIP_IF_NIL:             take_o = st_i.result_nil;
			fp_status_pkg::OP_SKIP_IF_NOT_NIL:         take_o = !st_i.result_nil;
			fp_status_pkg::OP_SKIP_IF_GE:              take_o = !st_i.below_zero;
			fp_status_pkg::OP_SKIP_IF_LT:              take_o = st_i.below_zero;
			fp_status_pkg::OP_SKIP_IF_GT:
				take_o = !st_i.result_nil && !st_i.below_zero;
			fp_status_pkg::OP_SKIP_IF_LE:
				take_o = st_i.result_nil || st_i.below_zero;
			fp_status_pkg::OP_SKIP_IF_NO_DIVZERO:      take_o = !st_i.divisor_nil;
			fp_status_pkg::OP_SKIP_IF_NO_ERROR:        take_o = !st_i.any_err;
			fp_status_pkg::OP_SKIP_IF_NO_OVF:          take_o = !st_i.exp_high;
			fp_status_pkg::OP_SKIP_IF_NO_UNF:          take_o = !st_i.exp_low;
			fp_status_pkg::OP_SKIP_IF_NO_FRACCARRY:    take_o = !st_i.frac_carry;
			fp_status_pkg::OP_SKIP_NO_HIGH_NO_DIVZERO:
				take_o = !st_i.exp_high && !st_i.divisor_nil;
			fp_status_pkg::OP_SKIP_NO_LOW_NO_DIVZERO:
				take_o = !st_i.exp_low && !st_i.divisor_nil;
			fp_status_pkg::OP_SKIP_NO_LOW_NO_HIGH:
				take_o = !st_i.exp_low && !st_i.exp_high;
			default: begin
				is_skip_o = 1'b0;
				take_o    = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// >>> core/fp_exp_wrap.sv
// exponent range check and wrap of an excess-64 result exponent
// assumes the raw exponent is the signed biased sum from the datapath
`timescale 1ns/1ns
`default_nettype none
module fp_exp_wrap (
	// raw biased exponent
	input  wire logic [8:0] raw_i,
	// wrapped field and faults
	output logic [6:0]      field_o,
	output logic            high_o,
	output logic            low_o
);
	always_comb begin
		high_o  = $signed(raw_i) > fp_status_pkg::EXP_MAX;
		low_o   = $signed(raw_i) < fp_status_pkg::EXP_MIN;
		// modulo 128 leaves field 128 off
		field_o = raw_i[6:0];
	end
endmodule
`default_nettype wire

// >>> bench/fp_status_skip_trap_unit_tb.sv
// self-checking bench for the floating-point status, skip and trap unit
// assumes the unit answers one cycle after each valid operation
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module fp_status_skip_trap_unit_tb;
	// unit identification; value is arbitrary
	localparam logic [3:0] KIND = 4'hA;

	logic                       clk_i;
	logic                       rst_i;
	logic                       op_valid_i;
	fp_status_pkg::op_req_s     op_i;
	fp_status_pkg::dp_result_s  dp_i;
	logic [31:0]                load_data_i;
	logic [14:0]                pc_o;
	logic                       skip_o;
	logic                       trap_o;
	logic                       result_write_o;
	logic [6:0]                 exp_field_o;
	logic [63:0]                status_o;
	logic [31:0]                store_data_o;
	logic                       store_valid_o;
	int                         fail_count;
	int                         checks;

	fp_status_skip_trap_unit #(.FPU_KIND(KIND)) i_dut (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.op_valid_i     (op_valid_i),
		.op_i           (op_i),
		.dp_i           (dp_i),
		.load_data_i    (load_data_i),
		.pc_o           (pc_o),
		.skip_o         (skip_o),
		.trap_o         (trap_o),
		.result_write_o (result_write_o),
		.exp_field_o    (exp_field_o),
		.status_o       (status_o),
		.store_data_o   (store_data_o),
		.store_valid_o  (store_valid_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one operation; valid stays high so calls may run back to back
	task automatic do_op(input fp_status_pkg::op_e o, input logic [14:0] p, input logic tw,
			input logic [8:0] ex, input logic [3:0] f);
		op_valid_i = 1'b1;
		op_i = {o, p, tw};
		dp_i = {ex, f};
		@(posedge clk_i);
		#1;
	endtask

	task automatic idle();
		op_valid_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	// skip decision from the low status byte
	function automatic logic want_skip(input fp_status_pkg::op_e o, input logic [7:0] s);
		case (o)
			fp_status_pkg::OP_SKIP_ALWAYS:             return 1'b1;
			fp_status_pkg::OP_SKIP_IF_NIL:             return s[6];
			fp_status_pkg::OP_SKIP_IF_NOT_NIL:         return !s[6];
			fp_status_pkg::OP_SKIP_IF_GE:              return !s[7];
			fp_status_pkg::OP_SKIP_IF_LT:              return s[7];
			fp_status_pkg::OP_SKIP_IF_GT:              return !s[6] && !s[7];
			fp_status_pkg::OP_SKIP_IF_LE:              return s[6] || s[7];
			fp_status_pkg::OP_SKIP_IF_NO_DIVZERO:      return !s[3];
			fp_status_pkg::OP_SKIP_IF_NO_ERROR:        return !s[0];
			fp_status_pkg::OP_SKIP_IF_NO_FRACCARRY:    return !s[4];
			fp_status_pkg::OP_SKIP_IF_NO_OVF:          return !s[1];
			fp_status_pkg::OP_SKIP_IF_NO_UNF:          return !s[2];
			fp_status_pkg::OP_SKIP_NO_HIGH_NO_DIVZERO: return !s[1] && !s[3];
			fp_status_pkg::OP_SKIP_NO_LOW_NO_DIVZERO:  return !s[2] && !s[3];
			fp_status_pkg::OP_SKIP_NO_LOW_NO_HIGH:     return !s[2] && !s[1];
			default:                                   return 1'b0;
		endcase
	endfunction

	// every skip op back to back, running past the top of the address space and wrapping to 0
	task automatic run_skips(input logic [7:0] s);
		fp_status_pkg::op_e o;
		logic [14:0]        p;
		logic               w;
		for (int k = fp_status_pkg::OP_NEVER_SKIP; k <= fp_status_pkg::OP_SKIP_NO_LOW_NO_HIGH; k++) begin
			o = fp_status_pkg::op_e'(k);
			p = 15'h7FF0 + 15'(k);
			w = want_skip(o, s);
			do_op(o, p, 1'b0, 9'h040, 4'h0);
			`CHK(skip_o, w)
			`CHK(pc_o, w ? p + 15'h0002 : p + 15'h0001)
		end
		idle();
	endtask

	task automatic test_reset();
		`CHK(status_o, {48'h0, KIND, 12'h000})
		`CHK(pc_o, 15'h0000)
		`CHK({skip_o, trap_o, store_valid_o}, 3'b000)
		$display("reset test done");
	endtask

	task automatic test_compare();
		for (int c = 0; c < 4; c++) begin
			do_op(fp_status_pkg::OP_COMPARE, 15'h0100, 1'b0, 9'h040, {1'b0, c[1], c[0], 1'b0});
			`CHK(status_o[7:0], {c[0], c[1], 6'b000000})
			`CHK({skip_o, pc_o}, {1'b0, 15'h0101})
			run_skips({c[0], c[1], 6'b000000});
		end
		$display("compare test done");
	endtask

	task automatic test_load_store();
		logic [31:0] lw;
		for (int k = 0; k < 16; k++) begin
			lw = {15'h1234 ^ 15'(k), 1'b0, KIND, 4'h0, 2'b11, 1'b0, k[3:0], |k[3:0]};
			load_data_i = {15'h1234 ^ 15'(k), 1'b1, 8'hFF, 2'b11, 1'b0, k[3:0], 1'b0};
			do_op(fp_status_pkg::OP_LOAD_STATUS, 15'h0200, 1'b0, 9'h040, 4'h0);
			`CHK(status_o, {32'h0, lw})
			do_op(fp_status_pkg::OP_STORE_STATUS, 15'h0201, 1'b0, 9'h040, 4'h0);
			`CHK({store_valid_o, store_data_o}, {1'b1, lw})
			run_skips(lw[7:0]);
		end
		$display("load store test done");
	endtask

	task automatic test_faults();
		load_data_i = 32'h0000_0000;
		do_op(fp_status_pkg::OP_LOAD_STATUS, 15'h0120, 1'b0, 9'h040, 4'h0);
		do_op(fp_status_pkg::OP_ARITH, 15'h0123, 1'b0, 9'h080, 4'h0);
		`CHK({result_write_o, exp_field_o, status_o[4:0]}, {1'b1, 7'h00, 5'b00011})
		`CHK(status_o[31:17], 15'h0123)
		do_op(fp_status_pkg::OP_ARITH, 15'h0200, 1'b0, 9'h1FF, 4'b0010);
		`CHK({exp_field_o, status_o[7], status_o[4:0]}, {7'h7F, 1'b1, 5'b00111})
		`CHK(status_o[31:17], 15'h0200)
		do_op(fp_status_pkg::OP_DIVIDE, 15'h0300, 1'b0, 9'h040, 4'b0101);
		`CHK({result_write_o, status_o[7:6], status_o[4:0]}, {1'b0, 2'b10, 5'b01111})
		do_op(fp_status_pkg::OP_ARITH, 15'h0301, 1'b0, 9'h040, 4'b1000);
		`CHK({result_write_o, exp_field_o, status_o[4:0]}, {1'b1, 7'h40, 5'b11111})
		do_op(fp_status_pkg::OP_ARITH, 15'h0302, 1'b0, 9'h040, 4'b0100);
		`CHK({trap_o, status_o[7:6], status_o[4:0]}, {1'b0, 2'b01, 5'b11111})
		do_op(fp_status_pkg::OP_CLEAR_ERRORS, 15'h0303, 1'b0, 9'h040, 4'h0);
		`CHK(status_o, {32'h0, 15'h0301, 1'b0, KIND, 4'h0, 2'b01, 6'b000000})
		do_op(fp_status_pkg::OP_DIVIDE, 15'h0310, 1'b0, 9'h041, 4'b0010);
		`CHK({result_write_o, exp_field_o, status_o[7:0]}, {1'b1, 7'h41, 8'h80})
		`CHK(status_o[31:17], 15'h0301)
		idle();
		$display("fault test done");
	endtask

	task automatic test_mid_reset();
		rst_i = 1'b1;
		do_op(fp_status_pkg::OP_TRAP_ON, 15'h0500, 1'b0, 9'h080, 4'b1111);
		rst_i = 1'b0;
		op_valid_i = 1'b0;
		test_reset();
		idle();
		`CHK({status_o[5], status_o[1], pc_o}, {2'b00, 15'h0000})
		$display("mid reset test done");
	endtask

	task automatic test_trap();
		do_op(fp_status_pkg::OP_TRAP_ON, 15'h0400, 1'b0, 9'h040, 4'h0);
		`CHK(status_o[5], 1'b1)
		do_op(fp_status_pkg::OP_ARITH, 15'h0401, 1'b0, 9'h080, 4'h0);
		`CHK({trap_o, status_o[1]}, 2'b01)
		do_op(fp_status_pkg::OP_FIXED, 15'h0402, 1'b1, 9'h040, 4'h0);
		`CHK({trap_o, pc_o}, {1'b0, 15'h0404})
		do_op(fp_status_pkg::OP_FIXED, 15'h0404, 1'b0, 9'h040, 4'h0);
		`CHK({trap_o, pc_o}, {1'b0, 15'h0405})
		do_op(fp_status_pkg::OP_COMPARE, 15'h0405, 1'b0, 9'h040, 4'b0100);
		`CHK({trap_o, pc_o, status_o[7:6]}, {1'b1, 15'h0405, 2'b00})
		do_op(fp_status_pkg::OP_COMPARE, 15'h0405, 1'b0, 9'h040, 4'b0100);
		`CHK({trap_o, pc_o, status_o[7:6]}, {1'b0, 15'h0406, 2'b01})
		do_op(fp_status_pkg::OP_TRAP_OFF, 15'h0406, 1'b0, 9'h040, 4'h0);
		`CHK({trap_o, status_o[5]}, 2'b00)
		idle();
		$display("trap test done");
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		$display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		stop_test();
	end

	initial begin
		fail_count = 0;
		checks = 0;
		rst_i = 1'b1;
		op_valid_i = 1'b0;
		op_i = '0;
		dp_i = '0;
		load_data_i = 32'h0000_0000;
		repeat (12) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		test_reset();
		test_compare();
		test_load_store();
		test_faults();
		test_trap();
		test_mid_reset();
		stop_test();
	end
endmodule
`default_nettype wire
